// [logic/sram_port_regs.svh]
// Register offsets, field positions, widths and reset values of the port
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define REG_CTRL_OFF 8'h00
`define REG_SNAP_OFF 8'h04
`define REG_STATUS_OFF 8'h08
`define REG_RDCNT_OFF 8'h0C
`define REG_WRCNT_OFF 8'h10
`define REG_IDLECNT_OFF 8'h14
`define APB_ADDR_W 8

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTRL_ORG_X18_BIT 0
`define CTRL_RESET 32'h0000_0000
`define STATUS_SNAP_DONE_BIT 0
`define STATUS_K_REF_BIT 1

// ****************************************************************
// Memory organisation
// ****************************************************************
`define DATA_W 36
`define HALF_DATA_W 18
`define ADDR_W 19
`define BYTE_W 9
`define BYTES 4
`define CNT_W 32

`endif

// [logic/sram_port_pkg.sv]
// Types and shared helpers of the two-word burst memory port
package sram_port_pkg;
   `include "sram_port_regs.svh"

   typedef enum logic [1:0] {
      CMD_IDLE = 2'b00,
      CMD_READ = 2'b01,
      CMD_WRITE = 2'b10
   } cmd_t;

   typedef logic [`DATA_W-1:0] word_t;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [`BYTES-1:0] lanes_t;

   // Active-low strobes to a per-bit write mask; x18 has two lanes only
   function automatic word_t lane_mask(input lanes_t strobe_n,
                                       input logic org_x18);
      word_t m;
      m = '0;
      for (int i = 0; i < `BYTES; i++) begin
         if (!strobe_n[i] && (!org_x18 || i < 2)) begin
            m[i*`BYTE_W +: `BYTE_W] = {`BYTE_W{1'b1}};
         end
      end
      return m;
   endfunction
endpackage

// [logic/level_sync.sv]
// Two-flop synchroniser for a level crossing into a clock domain
`timescale 1ns/10ps
module level_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic meta_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// [logic/pair_mem.sv]
// Word array with a two-word write port and a two-word registered read
`timescale 1ns/10ps
module pair_mem
   import sram_port_pkg::*;
(
   input wire logic clk,
   input wire logic we,
   input sram_port_pkg::addr_t waddr,
   input sram_port_pkg::word_t wdata1,
   input sram_port_pkg::word_t wmask1,
   input sram_port_pkg::word_t wdata2,
   input sram_port_pkg::word_t wmask2,
   input sram_port_pkg::addr_t raddr,
   output sram_port_pkg::word_t rdata1,
   output sram_port_pkg::word_t rdata2
);
   word_t mem [0:(1<<`ADDR_W)-1];
   addr_t waddr2;
   addr_t raddr2;

   // Second word sits at the partner location of the pair
   assign waddr2 = {waddr[`ADDR_W-1:1], ~waddr[0]};
   assign raddr2 = {raddr[`ADDR_W-1:1], ~raddr[0]};

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= (mem[waddr] & ~wmask1) | (wdata1 & wmask1);
         mem[waddr2] <= (mem[waddr2] & ~wmask2) | (wdata2 & wmask2);
      end
   end

   always_ff @(posedge clk) begin
      rdata1 <= mem[raddr];
      rdata2 <= mem[raddr2];
   end
endmodule

// [logic/ddr_burst_port.sv]
// Two-word burst double-data-rate memory port with an APB status window
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
// Behaviour
// - address, load strobe and direction registered on each rising K edge.
// - every transaction moves exactly two words in one clock period.
// - burst_word_select is address bit 0; a burst may start on either word.
// - load strobe high means idle cycle; address inputs are ignored.
// - write words sampled on rising K and rising K# edges.
// - read data timed by output clocks, or by K pair when both held high.
// - x18 uses data lines 0..17, x36 uses lines 0..35.
// - with load low, direction high reads and low writes.
// - low byte strobe writes its byte; high strobe leaves it unchanged.
// - x36 has four byte strobes, x18 has two.
// - rising C# times the first read word, rising C the second.
// - echo clock pair follows the read reference and runs freely.
module ddr_burst_port
   import sram_port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic k_clk,
   input wire logic k_n_clk,
   input wire logic c_clk,
   input wire logic c_n_clk,
   input wire logic load_strobe_n,
   input wire logic rw_sel,
   input wire logic [`ADDR_W-2:0] addr_hi,
   input wire logic burst_word_select,
   input wire sram_port_pkg::lanes_t byte_write_strobe_n,
   input wire sram_port_pkg::word_t shared_data_lines_i,
   output sram_port_pkg::word_t shared_data_lines_o,
   output sram_port_pkg::word_t shared_data_lines_oe,
   output logic echo_clk,
   output logic echo_clk_n
);
   import sram_port_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0] ctrl_reg;
   logic snap_req_reg;
   logic snap_ack_p;
   logic k_ref_p;
   logic org_x18_k;
   logic snap_req_k;
   logic snap_seen_reg;
   logic snap_ack_reg;
   logic c_hi_k;
   logic c_n_hi_k;
   logic use_k_reg;
   logic ref_clk;
   logic ref_n_clk;
   cmd_t cmd1_reg;
   cmd_t cmd2_reg;
   addr_t addr1_reg;
   addr_t addr2_reg;
   word_t wd1_reg;
   word_t wd2_reg;
   lanes_t wbe1_reg;
   lanes_t wbe2_reg;
   word_t rd1;
   word_t rd2;
   logic rd_pend_reg;
   logic mem_we;
   logic [`CNT_W-1:0] rd_cnt_reg;
   logic [`CNT_W-1:0] wr_cnt_reg;
   logic [`CNT_W-1:0] idle_cnt_reg;
   logic [`CNT_W-1:0] rd_snap_reg;
   logic [`CNT_W-1:0] wr_snap_reg;
   logic [`CNT_W-1:0] idle_snap_reg;
   word_t first_out_reg;
   word_t second_out_reg;
   logic first_oe_reg;
   logic second_oe_reg;
   logic [31:0] rdata_next;
   logic err_next;
   logic access;

   // ****************************************************************
   // APB slave, one wait state
   // ****************************************************************
   assign access = psel && penable && !pready;

   always_comb begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      case (paddr[`APB_ADDR_W-1:0])
         `REG_CTRL_OFF: rdata_next = ctrl_reg;
         `REG_SNAP_OFF: rdata_next = {31'h0000_0000, snap_req_reg};
         `REG_STATUS_OFF: begin
            rdata_next[`STATUS_SNAP_DONE_BIT] = snap_ack_p == snap_req_reg;
            rdata_next[`STATUS_K_REF_BIT] = k_ref_p;
         end
         `REG_RDCNT_OFF: rdata_next = rd_snap_reg;
         `REG_WRCNT_OFF: rdata_next = wr_snap_reg;
         `REG_IDLECNT_OFF: rdata_next = idle_snap_reg;
         default: err_next = 1'b1;
      endcase
      if (paddr[31:`APB_ADDR_W] != '0) begin
         rdata_next = 32'h0000_0000;
         err_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access && err_next;
         prdata <= (access && !pwrite) ? rdata_next : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (access && pwrite && !err_next &&
                   paddr[`APB_ADDR_W-1:0] == `REG_CTRL_OFF && pstrb[0]) begin
         ctrl_reg[`CTRL_ORG_X18_BIT] <= pwdata[`CTRL_ORG_X18_BIT];
      end
   end

   // Snapshot request toggles; a new one is dropped until the last has finished
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_req_reg <= 1'b0;
      end else if (access && pwrite && !err_next &&
                   paddr[`APB_ADDR_W-1:0] == `REG_SNAP_OFF &&
                   snap_ack_p == snap_req_reg) begin
         snap_req_reg <= ~snap_req_reg;
      end
   end

   level_sync ack_sync (.clk(pclk), .rst_n(presetn), .d(snap_ack_reg),
                        .q(snap_ack_p));
   level_sync ref_sync (.clk(pclk), .rst_n(presetn), .d(use_k_reg),
                        .q(k_ref_p));

   // ****************************************************************
   // Link domain crossings
   // ****************************************************************
   level_sync org_sync (.clk(k_clk), .rst_n(presetn),
                        .d(ctrl_reg[`CTRL_ORG_X18_BIT]), .q(org_x18_k));
   level_sync req_sync (.clk(k_clk), .rst_n(presetn), .d(snap_req_reg),
                        .q(snap_req_k));
   level_sync c_sync (.clk(k_clk), .rst_n(presetn), .d(c_clk),
                      .q(c_hi_k));
   level_sync cn_sync (.clk(k_clk), .rst_n(presetn), .d(c_n_clk),
                       .q(c_n_hi_k));

   // Both output clocks seen high selects the input pair
   always_ff @(posedge k_clk or negedge presetn) begin
      if (!presetn) begin
         use_k_reg <= 1'b0;
      end else begin
         use_k_reg <= c_hi_k && c_n_hi_k;
      end
   end

   // Counters are copied only on request, so the bus side reads them stable
   always_ff @(posedge k_clk or negedge presetn) begin
      if (!presetn) begin
         snap_seen_reg <= 1'b0;
         snap_ack_reg <= 1'b0;
         rd_snap_reg <= '0;
         wr_snap_reg <= '0;
         idle_snap_reg <= '0;
      end else begin
         snap_seen_reg <= snap_req_k;
         if (snap_req_k != snap_seen_reg) begin
            rd_snap_reg <= rd_cnt_reg;
            wr_snap_reg <= wr_cnt_reg;
            idle_snap_reg <= idle_cnt_reg;
            snap_ack_reg <= snap_req_k;
         end
      end
   end

   // ****************************************************************
   // Command pipeline
   // ****************************************************************
   always_ff @(posedge k_clk or negedge presetn) begin
      if (!presetn) begin
         cmd1_reg <= CMD_IDLE;
         addr1_reg <= '0;
      end else begin
         if (load_strobe_n) begin
            cmd1_reg <= CMD_IDLE;
         end else begin
            cmd1_reg <= rw_sel ? CMD_READ : CMD_WRITE;
            addr1_reg <= {addr_hi, burst_word_select};
         end
      end
   end

   always_ff @(posedge k_clk or negedge presetn) begin
      if (!presetn) begin
         cmd2_reg <= CMD_IDLE;
         addr2_reg <= '0;
         rd_pend_reg <= 1'b0;
      end else begin
         cmd2_reg <= cmd1_reg;
         addr2_reg <= addr1_reg;
         rd_pend_reg <= cmd1_reg == CMD_READ;
      end
   end

   // First write word on K, second on K#, each with its own strobes
   always_ff @(posedge k_clk) begin
      wd1_reg <= shared_data_lines_i;
      wbe1_reg <= byte_write_strobe_n;
   end

   always_ff @(posedge k_n_clk) begin
      wd2_reg <= shared_data_lines_i;
      wbe2_reg <= byte_write_strobe_n;
   end

   // Both words commit together; a read in that cycle sees old data
   assign mem_we = cmd2_reg == CMD_WRITE;

   pair_mem mem_inst (
      .clk(k_clk),
      .we(mem_we),
      .waddr(addr2_reg),
      .wdata1(wd1_reg),
      .wmask1(lane_mask(wbe1_reg, org_x18_k)),
      .wdata2(wd2_reg),
      .wmask2(lane_mask(wbe2_reg, org_x18_k)),
      .raddr(addr1_reg),
      .rdata1(rd1),
      .rdata2(rd2)
   );

   always_ff @(posedge k_clk or negedge presetn) begin
      if (!presetn) begin
         rd_cnt_reg <= '0;
         wr_cnt_reg <= '0;
         idle_cnt_reg <= '0;
      end else begin
         case (cmd1_reg)
            CMD_READ: rd_cnt_reg <= rd_cnt_reg + 1'b1;
            CMD_WRITE: wr_cnt_reg <= wr_cnt_reg + 1'b1;
            default: idle_cnt_reg <= idle_cnt_reg + 1'b1;
         endcase
      end
   end

   // ****************************************************************
   // Read launch and echo clocks
   // ****************************************************************
   // Clock select is quasi-static: the controller must not toggle C then
   assign ref_clk = use_k_reg ? k_clk : c_clk;
   assign ref_n_clk = use_k_reg ? k_n_clk : c_n_clk;

   always_ff @(posedge ref_n_clk or negedge presetn) begin
      if (!presetn) begin
         first_out_reg <= '0;
         first_oe_reg <= 1'b0;
      end else begin
         first_out_reg <= rd1;
         first_oe_reg <= rd_pend_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge presetn) begin
      if (!presetn) begin
         second_out_reg <= '0;
         second_oe_reg <= 1'b0;
      end else begin
         second_out_reg <= rd2;
         second_oe_reg <= first_oe_reg;
      end
   end

   // Low half of the reference period shows word one, high half word two
   assign shared_data_lines_o = ref_clk ? second_out_reg : first_out_reg;
   assign shared_data_lines_oe = (ref_clk ? second_oe_reg : first_oe_reg) ?
      (org_x18_k ? {{`HALF_DATA_W{1'b0}}, {`HALF_DATA_W{1'b1}}} : '1) :
      '0;
   assign echo_clk = ref_clk;
   assign echo_clk_n = ref_n_clk;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_idle_no_cmd: assert property (@(posedge k_clk)
      disable iff (!presetn) load_strobe_n |=> cmd1_reg == CMD_IDLE)
      else $error("idle cycle produced a command");
   a_addr_ignored: assert property (@(posedge k_clk)
      disable iff (!presetn) load_strobe_n |=> $stable(addr1_reg))
      else $error("address taken during idle cycle");
   a_addr_capture: assert property (@(posedge k_clk)
      disable iff (!presetn) !load_strobe_n |=>
      addr1_reg == $past({addr_hi, burst_word_select}))
      else $error("address not captured on load");
   a_dir_decode: assert property (@(posedge k_clk)
      disable iff (!presetn) !load_strobe_n |=>
      cmd1_reg == ($past(rw_sel) ? CMD_READ : CMD_WRITE))
      else $error("direction decoded wrongly");
   a_write_commit: assert property (@(posedge k_clk)
      disable iff (!presetn) (!load_strobe_n && !rw_sel) |=> ##1 mem_we)
      else $error("write not committed two edges after load");
   a_idle_no_write: assert property (@(posedge k_clk)
      disable iff (!presetn) load_strobe_n |=> ##1 !mem_we)
      else $error("idle cycle wrote memory");
   a_read_pending: assert property (@(posedge k_clk)
      disable iff (!presetn) (!load_strobe_n && rw_sel) |=> ##1 rd_pend_reg)
      else $error("read not scheduled for launch");
   a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("bus answer not one cycle");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (access && (paddr[`APB_ADDR_W-1:0] > `REG_IDLECNT_OFF ||
      paddr[31:`APB_ADDR_W] != '0)) |=> pslverr)
      else $error("unmapped address not refused");
endmodule

// [verification/burst_ctrl_model.sv]
// Behavioural memory controller driving the link side of the port
`timescale 1ns/10ps
`include "sram_port_regs.svh"
module burst_ctrl_model
   import sram_port_pkg::*;
(
   output logic k_clk,
   output logic k_n_clk,
   output logic c_clk,
   output logic c_n_clk,
   output logic load_strobe_n,
   output logic rw_sel,
   output logic [`ADDR_W-2:0] addr_hi,
   output logic burst_word_select,
   output sram_port_pkg::lanes_t byte_write_strobe_n,
   output sram_port_pkg::word_t dq_wire,
   input wire sram_port_pkg::word_t dq_o,
   input wire sram_port_pkg::word_t dq_oe,
   input wire logic echo_clk,
   input wire logic echo_clk_n,
   input wire logic use_k_ref
);
   logic c_dly, drv, ref_p, ref_n;
   word_t dval, flt;
   initial begin
      load_strobe_n = 1'b1;
      rw_sel = 1'b0;
      {addr_hi, burst_word_select} = '0;
      byte_write_strobe_n = '1;
      drv = 1'b0;
      dval = '0;
      flt = '0;
      c_dly = 1'b0;
      k_clk = 1'b0;
      #7;
      forever #32 k_clk = ~k_clk;
   end
   assign k_n_clk = ~k_clk;
   always @(k_clk) c_dly <= #8 k_clk;
   // Output clocks parked high select the input pair as reference
   assign c_clk = use_k_ref ? 1'b1 : c_dly;
   assign c_n_clk = use_k_ref ? 1'b1 : ~c_dly;
   assign ref_p = use_k_ref ? k_clk : c_clk;
   assign ref_n = use_k_ref ? k_n_clk : c_n_clk;
   // Undriven lines wander so stale data never looks valid
   always @(posedge k_clk) flt <= ~flt;
   assign dq_wire = (dq_oe & dq_o) | (~dq_oe & (drv ? dval : flt));

   task automatic cmd(input logic rd, input addr_t a);
      @(posedge k_clk);
      load_strobe_n <= 1'b0;
      rw_sel <= rd;
      {addr_hi, burst_word_select} <= a;
      @(posedge k_clk);
      load_strobe_n <= 1'b1;
      {addr_hi, burst_word_select} <= ~a;
   endtask

   task automatic wr(input addr_t a, input word_t w1, w2,
                     input lanes_t s1, s2);
      cmd(1'b0, a);
      drv <= 1'b1;
      dval <= w1;
      byte_write_strobe_n <= s1;
      @(posedge k_clk);
      dval <= w2;
      byte_write_strobe_n <= s2;
      @(posedge k_n_clk);
      drv <= 1'b0;
      byte_write_strobe_n <= ~s2;
   endtask

   task automatic rd(input addr_t a, output word_t w1, w2, o1, o2,
                     output logic [3:0] ec);
      cmd(1'b1, a);
      @(posedge k_clk);
      @(posedge ref_n);
      #16;
      w1 = dq_wire;
      o1 = dq_oe;
      ec[3:2] = {echo_clk, echo_clk_n};
      @(posedge ref_p);
      #16;
      w2 = dq_wire;
      o2 = dq_oe;
      ec[1:0] = {echo_clk, echo_clk_n};
   endtask

   task automatic idle(input int n, output logic seen);
      seen = 1'b0;
      drv <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge k_clk);
         rw_sel <= i[0];
         {addr_hi, burst_word_select} <= addr_t'(i * 12345);
         dval <= ~dval;
         #16;
         if (dq_oe !== '0) seen = 1'b1;
      end
      @(posedge k_clk);
      drv <= 1'b0;
   endtask
endmodule

// [verification/ddr_burst_port_bench.sv]
// Self-checking bench for the two-word burst memory port
`timescale 1ns/10ps
`include "sram_port_regs.svh"
module ddr_burst_port_bench;
   import sram_port_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic [3:0] pstrb;
   logic k_clk, k_n_clk, c_clk, c_n_clk, load_strobe_n, rw_sel;
   logic burst_word_select, echo_clk, echo_clk_n, use_k_ref;
   logic [`ADDR_W-2:0] addr_hi;
   lanes_t byte_write_strobe_n;
   word_t dq_i, dq_o, dq_oe;
   int err_count, tests_run, rd_n, wr_n;
   localparam addr_t ADR0 = 19'h0_0A5A;
   localparam addr_t A1 = 19'h3_1230;
   localparam addr_t A2 = 19'h0_7F00;
   localparam word_t D1 = 36'h1_2345_6789;
   localparam word_t D2 = 36'hF_EDCB_A987;

   ddr_burst_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .k_clk(k_clk), .k_n_clk(k_n_clk), .c_clk(c_clk), .c_n_clk(c_n_clk),
      .load_strobe_n(load_strobe_n), .rw_sel(rw_sel), .addr_hi(addr_hi),
      .burst_word_select(burst_word_select),
      .byte_write_strobe_n(byte_write_strobe_n),
      .shared_data_lines_i(dq_i), .shared_data_lines_o(dq_o),
      .shared_data_lines_oe(dq_oe), .echo_clk(echo_clk),
      .echo_clk_n(echo_clk_n));
   burst_ctrl_model i_ctrl (.k_clk(k_clk), .k_n_clk(k_n_clk),
      .c_clk(c_clk), .c_n_clk(c_n_clk), .load_strobe_n(load_strobe_n),
      .rw_sel(rw_sel), .addr_hi(addr_hi),
      .burst_word_select(burst_word_select),
      .byte_write_strobe_n(byte_write_strobe_n), .dq_wire(dq_i),
      .dq_o(dq_o), .dq_oe(dq_oe), .echo_clk(echo_clk),
      .echo_clk_n(echo_clk_n), .use_k_ref(use_k_ref));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [35:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask

   task automatic apb(input logic wr, input logic [31:0] a, wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 36'h1, {35'h0, pready});
   endtask

   task automatic rreg(input logic [31:0] a, exp, input string nm);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, '0, d, e);
      chk(nm, {4'h0, exp}, {4'h0, d});
      chk("slverr", 36'h0, {35'h0, e});
   endtask

   function automatic word_t merge(input word_t old, nw, input lanes_t s);
      word_t r;
      r = old;
      for (int i = 0; i < `BYTES; i++)
         if (!s[i]) r[i*`BYTE_W +: `BYTE_W] = nw[i*`BYTE_W +: `BYTE_W];
      return r;
   endfunction

   task automatic lw(input addr_t a, input word_t w1, w2,
                     input lanes_t s1, s2);
      i_ctrl.wr(a, w1, w2, s1, s2);
      wr_n++;
   endtask

   task automatic lr(input addr_t a, input word_t e1, e2, msk);
      word_t w1, w2, o1, o2;
      logic [3:0] ec;
      i_ctrl.rd(a, w1, w2, o1, o2, ec);
      rd_n++;
      chk("word1", e1 & msk, w1 & msk);
      chk("word2", e2 & msk, w2 & msk);
      chk("oe1", msk, o1);
      chk("oe2", msk, o2);
      chk("echo", 36'h6, {32'h0, ec});
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs;
      logic [31:0] d;
      logic e;
      rreg(32'(`REG_CTRL_OFF), `CTRL_RESET, "ctrl");
      apb(1'b0, 32'h18, '0, d, e);
      chk("unmapped err", 36'h1, {35'h0, e});
      chk("unmapped data", 36'h0, {4'h0, d});
      apb(1'b0, 32'h104, '0, d, e);
      chk("high addr err", 36'h1, {35'h0, e});
   endtask

   task automatic t_burst;
      lw(ADR0, D1, D2, '0, '0);
      lr(ADR0, D1, D2, '1);
      lr(ADR0 | 19'h1, D2, D1, '1);
   endtask

   task automatic t_lanes;
      lw(A1, D1, D2, '0, '0);
      lw(A1, ~D1, ~D2, 4'hA, 4'h5);
      lr(A1, merge(D1, ~D1, 4'hA), merge(D2, ~D2, 4'h5), '1);
   endtask

   task automatic t_idle;
      logic seen;
      i_ctrl.idle(6, seen);
      chk("idle drive", 36'h0, {35'h0, seen});
      lr(ADR0, D1, D2, '1);
   endtask

   task automatic t_kref;
      logic [31:0] d;
      logic e;
      use_k_ref = 1'b1;
      repeat (3) @(posedge k_clk);
      apb(1'b0, 32'(`REG_STATUS_OFF), '0, d, e);
      chk("k ref flag", 36'h1, {35'h0, d[`STATUS_K_REF_BIT]});
      lr(ADR0 | 19'h1, D2, D1, '1);
   endtask

   task automatic t_x18;
      logic [31:0] d;
      logic e;
      apb(1'b1, 32'(`REG_CTRL_OFF), 32'h1, d, e);
      lw(A2, D1, D2, '0, '0);
      lw(A2, ~D1, ~D2, 4'h3, 4'h3);
      lr(A2, D1, D2, 36'h0_0003_FFFF);
   endtask

   task automatic t_snap;
      logic [31:0] d;
      logic e;
      int n;
      n = 0;
      apb(1'b1, 32'(`REG_SNAP_OFF), 32'h1, d, e);
      do begin
         apb(1'b0, 32'(`REG_STATUS_OFF), '0, d, e);
         n++;
      end while (d[`STATUS_SNAP_DONE_BIT] !== 1'b1 && n < 50);
      chk("snap done", 36'h1, {35'h0, d[`STATUS_SNAP_DONE_BIT]});
      rreg(32'(`REG_RDCNT_OFF), 32'(rd_n), "reads");
      rreg(32'(`REG_WRCNT_OFF), 32'(wr_n), "writes");
      rreg(32'(`REG_SNAP_OFF), 32'h1, "snap req");
   endtask

   task automatic summarize;
      if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ****************************************************************
   // Run
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   initial begin
      // Deferred update so every reset process sees the falling edge
      presetn <= 1'b0;
      {psel, penable, pwrite, use_k_ref} = '0;
      {paddr, pwdata} = '0;
      pstrb = 4'hF;
      {err_count, tests_run, rd_n, wr_n} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      repeat (4) @(posedge k_clk);
      t_burst;
      t_lanes;
      t_idle;
      t_kref;
      t_x18;
      t_snap;
      summarize;
   end

   // Whole run needs a few microseconds; this only cuts a hang short
   initial begin
      #200000;
      err_count++;
      summarize;
   end
endmodule
